// ==== ara_pkg.sv ====
/*
  Shared constants and types for the cipher round assist datapath.
  Assumes a single 100 MHz core clock and an AXI4-Lite control path.
*/
package ara_pkg;

  // ****************
  // Register map and field positions
  // ****************
  localparam logic [7:0] ARA_CTL0_OFS = 8'h00;
  localparam logic [7:0] ARA_CTL4_OFS = 8'h04;
  localparam logic [7:0] ARA_FEAT_OFS = 8'h08;
  localparam logic [7:0] ARA_STAT_OFS = 8'h0c;
  localparam int ARA_EM_BIT = 2;
  localparam int ARA_TS_BIT = 3;
  localparam int ARA_OSFX_BIT = 9;
  localparam int ARA_FEAT_BIT = 25;
  localparam logic ARA_EM_RST = 1'b0;
  localparam logic ARA_TS_RST = 1'b0;
  localparam logic ARA_OSFX_RST = 1'b1;
  localparam logic ARA_FEAT_RST = 1'b1;
  localparam logic [1:0] ARA_RESP_OKAY = 2'b00;
  localparam logic [1:0] ARA_RESP_SLVERR = 2'b10;

  // ****************
  // Field arithmetic constants
  // ****************
  localparam logic [7:0] ARA_GF_POLY = 8'h1b;
  localparam logic [7:0] ARA_AFFINE_C = 8'h63;
  localparam logic [7:0] ARA_IMC_E = 8'h0e;
  localparam logic [7:0] ARA_IMC_B = 8'h0b;
  localparam logic [7:0] ARA_IMC_D = 8'h0d;
  localparam logic [7:0] ARA_IMC_9 = 8'h09;
  localparam logic [16:0] ARA_REAL_LIMIT = 17'h0ffff;
  localparam logic [16:0] ARA_OPND_LAST = 17'h0000f;
  localparam int ARA_CANON_MSB = 47;

  // ****************
  // Enumerations
  // ****************
  typedef enum logic [1:0] {
    ARA_OP_ENC_LAST = 2'b00,
    ARA_OP_INV_MIX = 2'b01,
    ARA_OP_KEY_ASSIST = 2'b10,
    ARA_OP_NONE = 2'b11
  } ara_op_t;

  typedef enum logic [2:0] {
    ARA_MODE_REAL = 3'b000,
    ARA_MODE_V86 = 3'b001,
    ARA_MODE_PROT = 3'b010,
    ARA_MODE_COMPAT = 3'b011,
    ARA_MODE_LONG = 3'b100
  } ara_mode_t;

  typedef enum logic [2:0] {
    ARA_FLT_NONE = 3'b000,
    ARA_FLT_UD = 3'b001,
    ARA_FLT_NM = 3'b010,
    ARA_FLT_GP = 3'b011,
    ARA_FLT_SS = 3'b100,
    ARA_FLT_PF = 3'b101
  } ara_fault_t;

endpackage

// ==== ara_round_assist.sv ====
/*
  Execution datapath and fault checks for the final encryption round,
  the inverse column mix and the round key expansion assist.
  Assumes the pipeline presents all operands, the mode and the memory
  check results in one cycle, and that control bits are set over AXI4-Lite.
*/
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
// What this block does
// - Final round: row shift, substitution, no mix
// - XOR round key into low half, upper kept
// - First source equals destination; key may be memory
// - Inverse column mix of source into low half
// - Key assist splits source into four words
// - Zero-extended constant; low word substituted word one
// - Words one and three: rotated, substituted, constant XOR
// - Misaligned memory operand gives protection fault
// - Task switched bit set gives not-available fault
// - Emulation bit set gives invalid opcode
// - Vector state support clear gives invalid opcode
// - Feature bit zero gives invalid opcode
// - Lock prefix gives invalid opcode
// - Real mode operand beyond FFFFH faults
// - Non-canonical address: protection or stack fault
// - Protected mode segment faults, code zero
// - Virtual-8086 as real mode plus page fault
// - Compatibility mode faults as protected mode
// - Feature register reports one in bit 25
`timescale 1ns/100ps
module ara_round_assist
  import ara_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pipeline request.
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [127:0] req_src1,
  input wire logic [127:0] req_src2,
  input wire logic [255:0] req_dest_old,
  input wire logic [4:0] req_src1_idx,
  input wire logic [4:0] req_dest_idx,
  input wire logic [7:0] req_imm8,
  input wire logic req_lock,
  input wire logic [2:0] req_mode,
  // Memory operand checks.
  input wire logic req_mem,
  input wire logic [63:0] req_addr,
  input wire logic req_stack_seg,
  input wire logic req_seg_fault,
  input wire logic req_page_fault,
  input wire logic [31:0] req_pf_code,
  // Pipeline answer.
  output logic done,
  output logic wr_en,
  output logic [255:0] result,
  output logic [2:0] fault,
  output logic [31:0] fault_err,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************
  // Field arithmetic
  // ****************

  // Doubling in the cipher field.
  function automatic logic [7:0] ara_xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? ARA_GF_POLY : 8'h00);
  endfunction

  // Shift-and-add multiply; small constants keep the real cost low.
  function automatic logic [7:0] ara_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] s;
    p = 8'h00;
    s = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) begin
        p = p ^ s;
      end
      s = ara_xt(s);
    end
    return p;
  endfunction

  // Substitution as inverse (a to the 254th) and affine map.
  // Logic instead of a table keeps the file short; timing is the cost.
  function automatic logic [7:0] ara_sbox(input logic [7:0] a);
    logic [7:0] s;
    logic [7:0] r;
    s = a;
    r = 8'h01;
    for (int k = 1; k < 8; k++) begin
      s = ara_mul(s, s);
      r = ara_mul(r, s);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^
           {r[3:0], r[7:4]} ^ ARA_AFFINE_C;
  endfunction

  // ****************
  // Datapath
  // ****************
  logic [127:0] enc_state;
  logic [127:0] imc_state;
  logic [127:0] key_out;
  logic [31:0] sub_w1;
  logic [31:0] sub_w3;
  logic [31:0] imm_word;
  logic [31:0] kw [4];

  // Per byte: row shift then substitution, and inverse column mix.
  // Byte i sits at row i%4, column i/4, with byte 0 in bits 7:0.
  for (genvar i = 0; i < 16; i++) begin : g_byte
    localparam int R = i % 4;
    localparam int C = i / 4;
    localparam int SRC = R + 4 * ((C + R) % 4);
    assign enc_state[8*i +: 8] = ara_sbox(req_src1[8*SRC +: 8]);
    assign imc_state[8*i +: 8] =
        ara_mul(req_src2[8*(4*C + R) +: 8], ARA_IMC_E) ^
        ara_mul(req_src2[8*(4*C + (R + 1) % 4) +: 8], ARA_IMC_B) ^
        ara_mul(req_src2[8*(4*C + (R + 2) % 4) +: 8], ARA_IMC_D) ^
        ara_mul(req_src2[8*(4*C + (R + 3) % 4) +: 8], ARA_IMC_9);
  end

  // Word split in ascending order, word 0 lowest.
  for (genvar w = 0; w < 4; w++) begin : g_word
    assign kw[w] = req_src2[32*w +: 32];
  end

  // Substituted words; the constant is the zero-extended immediate.
  for (genvar b = 0; b < 4; b++) begin : g_subw
    assign sub_w1[8*b +: 8] = ara_sbox(kw[1][8*b +: 8]);
    assign sub_w3[8*b +: 8] = ara_sbox(kw[3][8*b +: 8]);
  end
  assign imm_word = {24'h000000, req_imm8};

  // Rotation moves byte 0 to the top, as in the standard.
  assign key_out[31:0] = sub_w1;
  assign key_out[63:32] = {sub_w1[7:0], sub_w1[31:8]} ^ imm_word;
  assign key_out[95:64] = sub_w3;
  assign key_out[127:96] = {sub_w3[7:0], sub_w3[31:8]} ^ imm_word;

  // ****************
  // Fault checks
  // ****************
  logic emul_reg;
  logic tsw_reg;
  logic vss_reg;
  logic feat_reg;
  logic op_bad;
  logic ud_hit;
  logic nm_hit;
  logic [16:0] real_end;
  logic real_over;
  logic non_canon;
  logic paging_on;
  logic [2:0] flt_next;
  logic [31:0] err_next;
  logic [127:0] low_next;

  assign op_bad = (req_op == ARA_OP_NONE) ||
                  (req_op == ARA_OP_ENC_LAST && req_src1_idx != req_dest_idx);
  assign ud_hit = op_bad || req_lock || emul_reg || !vss_reg || !feat_reg;
  assign nm_hit = tsw_reg;
  assign real_end = {1'b0, req_addr[15:0]} + ARA_OPND_LAST;
  assign real_over = (req_addr[63:16] != 48'h0) || (real_end > ARA_REAL_LIMIT);
  assign non_canon = (req_addr[63:ARA_CANON_MSB] != {17{1'b0}}) &&
                     (req_addr[63:ARA_CANON_MSB] != {17{1'b1}});
  assign paging_on = (req_mode != ARA_MODE_REAL);

  // Priority: opcode faults, then not-available, then the memory operand.
  always_comb begin
    flt_next = ARA_FLT_NONE;
    err_next = 32'h00000000;
    if (ud_hit) begin
      flt_next = ARA_FLT_UD;
    end else if (nm_hit) begin
      flt_next = ARA_FLT_NM;
    end else if (req_mem) begin
      if (req_addr[3:0] != 4'h0) begin
        flt_next = ARA_FLT_GP;
      end else if (req_mode == ARA_MODE_REAL || req_mode == ARA_MODE_V86) begin
        if (real_over) begin
          flt_next = ARA_FLT_GP;
        end
      end else if (req_mode == ARA_MODE_LONG) begin
        if (non_canon) begin
          flt_next = req_stack_seg ? ARA_FLT_SS : ARA_FLT_GP;
        end
      end else if (req_seg_fault) begin
        flt_next = req_stack_seg ? ARA_FLT_SS : ARA_FLT_GP;
      end
      if (flt_next == ARA_FLT_NONE && req_page_fault && paging_on) begin
        flt_next = ARA_FLT_PF;
        err_next = req_pf_code;
      end
    end
  end

  // Result selection for the low half.
  always_comb begin
    case (req_op)
      ARA_OP_ENC_LAST: low_next = enc_state ^ req_src2;
      ARA_OP_INV_MIX: low_next = imc_state;
      ARA_OP_KEY_ASSIST: low_next = key_out;
      default: low_next = 128'h0;
    endcase
  end

  // ****************
  // Answer registers
  // ****************

  // One-cycle answer; a faulting request never asserts the write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      wr_en <= 1'b0;
      fault <= ARA_FLT_NONE;
      fault_err <= 32'h00000000;
    end else begin
      done <= req_valid;
      wr_en <= req_valid && (flt_next == ARA_FLT_NONE);
      fault <= req_valid ? flt_next : ARA_FLT_NONE;
      fault_err <= req_valid ? err_next : 32'h00000000;
    end
  end

  // The destination upper half is carried through untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 256'h0;
    end else if (req_valid && flt_next == ARA_FLT_NONE) begin
      result <= {req_dest_old[255:128], low_next};
    end
  end

  // Bookkeeping for status reads: last fault and faults seen.
  logic [2:0] last_flt_reg;
  logic [15:0] flt_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_flt_reg <= ARA_FLT_NONE;
      flt_cnt_reg <= 16'h0000;
    end else if (req_valid) begin
      last_flt_reg <= flt_next;
      if (flt_next != ARA_FLT_NONE) begin
        flt_cnt_reg <= flt_cnt_reg + 16'h0001;
      end
    end
  end

  // ****************
  // AXI4-Lite slave
  // ****************
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;

  // Control writes; address and data are taken together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emul_reg <= ARA_EM_RST;
      tsw_reg <= ARA_TS_RST;
      vss_reg <= ARA_OSFX_RST;
      feat_reg <= ARA_FEAT_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ARA_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ARA_RESP_OKAY;
        if (s_axi_awaddr == ARA_CTL0_OFS) begin
          if (s_axi_wstrb[0]) begin
            emul_reg <= s_axi_wdata[ARA_EM_BIT];
            tsw_reg <= s_axi_wdata[ARA_TS_BIT];
          end
        end else if (s_axi_awaddr == ARA_CTL4_OFS) begin
          if (s_axi_wstrb[1]) begin
            vss_reg <= s_axi_wdata[ARA_OSFX_BIT];
          end
        end else if (s_axi_awaddr == ARA_FEAT_OFS) begin
          if (s_axi_wstrb[3]) begin
            feat_reg <= s_axi_wdata[ARA_FEAT_BIT];
          end
        end else if (s_axi_awaddr != ARA_STAT_OFS) begin
          s_axi_bresp <= ARA_RESP_SLVERR;
        end
      end
    end
  end

  // Reads; status writes are accepted and ignored, as it is read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ARA_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ARA_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == ARA_CTL0_OFS) begin
        s_axi_rdata[ARA_EM_BIT] <= emul_reg;
        s_axi_rdata[ARA_TS_BIT] <= tsw_reg;
      end else if (s_axi_araddr == ARA_CTL4_OFS) begin
        s_axi_rdata[ARA_OSFX_BIT] <= vss_reg;
      end else if (s_axi_araddr == ARA_FEAT_OFS) begin
        s_axi_rdata[ARA_FEAT_BIT] <= feat_reg;
      end else if (s_axi_araddr == ARA_STAT_OFS) begin
        s_axi_rdata <= {flt_cnt_reg, 13'h0000, last_flt_reg};
      end else begin
        s_axi_rresp <= ARA_RESP_SLVERR;
      end
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DONE_NEXT: assert property (req_valid |=> done)
    else $error("Request not answered in the next cycle.");
  AST_FAULT_NO_WR: assert property (done && fault != ARA_FLT_NONE |-> !wr_en)
    else $error("Write asserted with a fault.");
  AST_EM_UD: assert property (req_valid && emul_reg |=> fault == ARA_FLT_UD)
    else $error("Emulation bit did not give invalid opcode.");
  AST_OSFX_UD: assert property (req_valid && !vss_reg |=> fault == ARA_FLT_UD)
    else $error("Vector state bit clear did not give invalid opcode.");
  AST_FEAT_UD: assert property (req_valid && !feat_reg |=> fault == ARA_FLT_UD)
    else $error("Feature bit zero did not give invalid opcode.");
  AST_LOCK_UD: assert property (req_valid && req_lock |=> fault == ARA_FLT_UD)
    else $error("Lock prefix did not give invalid opcode.");
  AST_TS_NM: assert property (req_valid && tsw_reg && !ud_hit
    |=> fault == ARA_FLT_NM && !wr_en)
    else $error("Task switched bit did not give not-available fault.");
  AST_ALIGN_GP: assert property (req_valid && !ud_hit && !nm_hit && req_mem &&
    req_addr[3:0] != 4'h0 |=> fault == ARA_FLT_GP && fault_err == 32'h0)
    else $error("Misaligned operand did not give protection fault.");
  AST_UPPER_KEPT: assert property (done && wr_en
    |-> result[255:128] == $past(req_dest_old[255:128]))
    else $error("Destination upper half changed.");
  AST_KEY_CONST: assert property (req_valid && req_op == ARA_OP_KEY_ASSIST &&
    flt_next == ARA_FLT_NONE |=> (result[63:32] ^ $past(imm_word)) ==
    {result[7:0], result[31:8]})
    else $error("Key assist word one mismatch.");
  AST_HELD_ON_FAULT: assert property (done && !wr_en |-> $stable(result))
    else $error("Result changed on a faulting request.");

  COV_ENC_OK: cover property (done && wr_en && $past(req_op) == ARA_OP_ENC_LAST);
  COV_KEY_OK: cover property (done && wr_en && $past(req_op) == ARA_OP_KEY_ASSIST);
  COV_GP: cover property (done && fault == ARA_FLT_GP);
  COV_PF: cover property (done && fault == ARA_FLT_PF);

endmodule

// ==== ara_core_model.sv ====
/*
  Pipeline model that issues one request at a time to the round assist block
  and captures the answer.
  Assumes the caller runs its tasks from one process, starting after reset.
*/
`timescale 1ns/100ps
module ara_core_model
  import ara_pkg::*;
#(
  parameter logic [31:0] PF_CODE = 32'h0000_0006
)
(
  // Clock and answer.
  input wire logic aclk,
  input wire logic done,
  input wire logic wr_en,
  input wire logic [255:0] result,
  input wire logic [2:0] fault,
  input wire logic [31:0] fault_err,
  // Request.
  output logic req_valid,
  output logic [1:0] req_op,
  output logic [127:0] req_src1,
  output logic [127:0] req_src2,
  output logic [255:0] req_dest_old,
  output logic [4:0] req_src1_idx,
  output logic [4:0] req_dest_idx,
  output logic [7:0] req_imm8,
  output logic req_lock,
  output logic [2:0] req_mode,
  output logic req_mem,
  output logic [63:0] req_addr,
  output logic req_stack_seg,
  output logic req_seg_fault,
  output logic req_page_fault,
  output logic [31:0] req_pf_code
);
  // ****************
  // Knobs and captured answer
  // ****************
  // Flags: 0 memory, 1 stack, 2 segment, 3 paging, 4 lock, 5 index mismatch.
  logic [2:0] k_mode = ARA_MODE_LONG;
  logic [63:0] k_addr = 64'h0;
  logic [5:0] k_fl = 6'h00;
  logic g_done, g_wr;
  logic [255:0] g_res;
  logic [2:0] g_flt;
  logic [31:0] g_err;

  // All requests start idle so nothing is taken during reset.
  initial begin
    {req_valid, req_op, req_src1, req_src2, req_dest_old, req_src1_idx, req_dest_idx,
     req_imm8, req_lock, req_mode, req_mem, req_addr, req_stack_seg, req_seg_fault,
     req_page_fault, req_pf_code} = '0;
  end

  // One request pulse; operands are scrambled once released.
  task automatic issue(input logic [1:0] op, input logic [127:0] s1, input logic [127:0] s2,
                       input logic [255:0] old, input logic [7:0] imm);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_src1 <= s1;
    req_src2 <= s2;
    req_dest_old <= old;
    req_imm8 <= imm;
    req_src1_idx <= 5'd3;
    req_dest_idx <= k_fl[5] ? 5'd4 : 5'd3;
    req_mem <= k_fl[0];
    req_stack_seg <= k_fl[1];
    req_seg_fault <= k_fl[2];
    req_page_fault <= k_fl[3];
    req_lock <= k_fl[4];
    req_mode <= k_mode;
    req_addr <= k_addr;
    req_pf_code <= PF_CODE;
    @(posedge aclk);
    req_valid <= 1'b0;
    req_src1 <= ~s1;
    req_src2 <= ~s2;
    req_dest_old <= ~old;
    #1;
    g_done = done;
    g_wr = wr_en;
    g_res = result;
    g_flt = fault;
    g_err = fault_err;
  endtask
endmodule

// ==== ara_round_assist_tb.sv ====
/*
  Self-checking bench for the round assist datapath and its control registers.
  Assumes the core model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module ara_round_assist_tb
  import ara_pkg::*;
;
  // ****************
  // Signals and instances
  // ****************
  localparam logic [31:0] PFC = 32'h0000_0006;
  localparam logic [127:0] S1 = 128'h3243f6a8885a308d313198a2e0370734;
  localparam logic [127:0] K = 128'h2b7e151628aed2a6abf7158809cf4f3c;
  localparam logic [255:0] OLD = {128'h0123456789abcdeffedcba9876543210, {16{8'ha5}}};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, req_pf_code, fault_err;
  wire logic req_valid, req_lock, req_mem, req_stack_seg, req_seg_fault, req_page_fault;
  wire logic done, wr_en;
  wire logic [1:0] req_op;
  wire logic [2:0] req_mode, fault;
  wire logic [4:0] req_src1_idx, req_dest_idx;
  wire logic [7:0] req_imm8;
  wire logic [63:0] req_addr;
  wire logic [127:0] req_src1, req_src2;
  wire logic [255:0] req_dest_old, result;
  logic [255:0] last = '0;
  int n_mismatch = 0, check_count = 0, nflt = 0;

  ara_round_assist dut_u (
    .aclk, .aresetn, .req_valid, .req_op, .req_src1, .req_src2, .req_dest_old,
    .req_src1_idx, .req_dest_idx, .req_imm8, .req_lock, .req_mode, .req_mem, .req_addr,
    .req_stack_seg, .req_seg_fault, .req_page_fault, .req_pf_code, .done, .wr_en,
    .result, .fault, .fault_err, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ara_core_model #(.PF_CODE(PFC)) u_core (
    .aclk, .done, .wr_en, .result, .fault, .fault_err, .req_valid, .req_op, .req_src1,
    .req_src2, .req_dest_old, .req_src1_idx, .req_dest_idx, .req_imm8, .req_lock,
    .req_mode, .req_mem, .req_addr, .req_stack_seg,
    .req_seg_fault, .req_page_fault, .req_pf_code
  );

  // Free-running core clock.
  always #5 aclk = ~aclk;

  // ****************
  // Reference transforms
  // ****************
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? ARA_GF_POLY : 8'h00);
    end
    return r;
  endfunction

  // Slow inverse search, but it needs no table to be trusted.
  function automatic logic [7:0] sb(input logic [7:0] x);
    logic [7:0] y, s, r;
    y = 8'h00;
    for (int i = 1; i < 256; i++) if (gm(x, 8'(i)) == 8'h01) y = 8'(i);
    s = y;
    r = y;
    for (int k = 0; k < 4; k++) begin
      s = {s[6:0], s[7]};
      r ^= s;
    end
    return r ^ ARA_AFFINE_C;
  endfunction

  function automatic logic [127:0] enc(input logic [127:0] s, input logic [127:0] k);
    logic [127:0] o;
    for (int i = 0; i < 16; i++) o[8*i+:8] = sb(s[8*((((i/4)+(i%4))%4)*4+(i%4))+:8]);
    return o ^ k;
  endfunction

  function automatic logic [127:0] imc(input logic [127:0] s);
    logic [127:0] o;
    int c;
    for (int i = 0; i < 16; i++) begin
      c = i - i % 4;
      o[8*i+:8] = gm(s[8*(c+i%4)+:8], ARA_IMC_E) ^ gm(s[8*(c+(i+1)%4)+:8], ARA_IMC_B)
                ^ gm(s[8*(c+(i+2)%4)+:8], ARA_IMC_D) ^ gm(s[8*(c+(i+3)%4)+:8], ARA_IMC_9);
    end
    return o;
  endfunction

  function automatic logic [31:0] sw(input logic [31:0] w);
    logic [31:0] o;
    for (int j = 0; j < 4; j++) o[8*j+:8] = sb(w[8*j+:8]);
    return o;
  endfunction

  function automatic logic [127:0] kga(input logic [127:0] s, input logic [7:0] m);
    logic [31:0] a, b, rc;
    a = sw(s[63:32]);
    b = sw(s[127:96]);
    rc = {24'h0, m};
    return {{b[7:0], b[31:8]} ^ rc, b, {a[7:0], a[31:8]} ^ rc, a};
  endfunction

  // ****************
  // Bus and check tasks
  // ****************
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // A successful register-operand request in 64-bit mode.
  task automatic ok(input logic [1:0] op, input logic [127:0] k, input logic [7:0] m,
                    input logic [127:0] e);
    u_core.issue(op, S1, k, OLD, m);
    chk("done", 1'b1, u_core.g_done);
    chk("wr_en", 1'b1, u_core.g_wr);
    chk("fault", ARA_FLT_NONE, u_core.g_flt);
    chk("result", {OLD[255:128], e}, u_core.g_res);
    last = {OLD[255:128], e};
  endtask

  // A request with chosen mode, address and flags; a fault must hold the result.
  task automatic bad(input logic [1:0] op, input logic [2:0] md, input logic [63:0] ad,
                     input logic [5:0] fl, input logic [2:0] f, input logic [31:0] er);
    u_core.k_mode = md;
    u_core.k_addr = ad;
    u_core.k_fl = fl;
    u_core.issue(op, S1, K, OLD, 8'h01);
    if (f === ARA_FLT_NONE) last = {OLD[255:128], enc(S1, K)};
    else nflt++;
    chk("done", 1'b1, u_core.g_done);
    chk("wr_en", f === ARA_FLT_NONE, u_core.g_wr);
    chk("fault", f, u_core.g_flt);
    chk("fault_err", er, u_core.g_err);
    chk("result", last, u_core.g_res);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axr(ARA_CTL0_OFS, d, r);
    chk("ctl0 bits", {ARA_TS_RST, ARA_EM_RST}, d[3:2]);
    chk("ctl0 resp", ARA_RESP_OKAY, r);
    axr(ARA_CTL4_OFS, d, r);
    chk("ctl4 bit", ARA_OSFX_RST, d[9]);
    axr(ARA_FEAT_OFS, d, r);
    chk("feature bit", 1'b1, d[25]);
    axr(8'h10, d, r);
    chk("unmapped rresp", ARA_RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, d);
    axw(8'h10, 32'hffff_ffff, 4'hf, r);
    chk("unmapped bresp", ARA_RESP_SLVERR, r);
    $display("test regs done");
  endtask

  task automatic t_ops();
    ok(ARA_OP_ENC_LAST, K, 8'h00, enc(S1, K));
    ok(ARA_OP_INV_MIX, K, 8'h00, imc(K));
    ok(ARA_OP_KEY_ASSIST, K, 8'h80, kga(K, 8'h80));
    ok(ARA_OP_KEY_ASSIST, S1, 8'h01, kga(S1, 8'h01));
    $display("test ops done");
  endtask

  task automatic t_mem();
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 64'h1008, 6'h01, ARA_FLT_GP, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 64'h1008, 6'h00, ARA_FLT_NONE, 0);
    bad(ARA_OP_INV_MIX, ARA_MODE_PROT, 64'h1004, 6'h01, ARA_FLT_GP, 0);
    bad(ARA_OP_KEY_ASSIST, ARA_MODE_REAL, 64'h10000, 6'h01, ARA_FLT_GP, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_REAL, 64'hfff0, 6'h01, ARA_FLT_NONE, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 64'h8000_0000_0000, 6'h01, ARA_FLT_GP, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 64'h8000_0000_0000, 6'h03, ARA_FLT_SS, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_PROT, 64'h100, 6'h05, ARA_FLT_GP, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_PROT, 64'h100, 6'h07, ARA_FLT_SS, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_V86, 64'h100, 6'h09, ARA_FLT_PF, PFC);
    bad(ARA_OP_ENC_LAST, ARA_MODE_V86, 64'h10000, 6'h01, ARA_FLT_GP, 0);
    bad(ARA_OP_KEY_ASSIST, ARA_MODE_COMPAT, 64'h100, 6'h09, ARA_FLT_PF, PFC);
    bad(ARA_OP_INV_MIX, ARA_MODE_COMPAT, 64'h100, 6'h05, ARA_FLT_GP, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 0, 6'h20, ARA_FLT_UD, 0);
    bad(ARA_OP_KEY_ASSIST, ARA_MODE_REAL, 0, 6'h10, ARA_FLT_UD, 0);
    bad(ARA_OP_NONE, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_UD, 0);
    $display("test mem done");
  endtask

  task automatic t_ctl();
    logic [31:0] d;
    logic [1:0] r;
    axw(ARA_CTL0_OFS, 32'h8, 4'h0, r);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_NONE, 0);
    axw(ARA_CTL0_OFS, 32'h4, 4'h1, r);
    chk("bresp", ARA_RESP_OKAY, r);
    bad(ARA_OP_INV_MIX, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_UD, 0);
    axw(ARA_CTL0_OFS, 32'h8, 4'h1, r);
    bad(ARA_OP_ENC_LAST, ARA_MODE_PROT, 0, 6'h00, ARA_FLT_NM, 0);
    bad(ARA_OP_ENC_LAST, ARA_MODE_PROT, 0, 6'h10, ARA_FLT_UD, 0);
    axw(ARA_CTL0_OFS, 32'h0, 4'h1, r);
    axw(ARA_CTL4_OFS, 32'h0, 4'h2, r);
    bad(ARA_OP_KEY_ASSIST, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_UD, 0);
    axw(ARA_CTL4_OFS, 32'h200, 4'h2, r);
    axw(ARA_FEAT_OFS, 32'h0, 4'h8, r);
    axr(ARA_FEAT_OFS, d, r);
    chk("feature cleared", 1'b0, d[25]);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_UD, 0);
    axw(ARA_FEAT_OFS, 32'h0200_0000, 4'h8, r);
    bad(ARA_OP_ENC_LAST, ARA_MODE_LONG, 0, 6'h00, ARA_FLT_NONE, 0);
    axr(ARA_STAT_OFS, d, r);
    chk("fault count", nflt[15:0], d[31:16]);
    $display("test ctl done");
  endtask

  // ****************
  // Sequence and verdict
  // ****************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for twelve cycles, then the scenarios in order.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ops();
    t_mem();
    t_ctl();
    stop_test();
  end

  // About 110 cycles are expected; 3000 cycles, over twenty times that, means a hang.
  initial begin
    #30000;
    n_mismatch++;
    stop_test();
  end
endmodule
